// ### esdi_pkg.sv
// Constants, types and helpers shared by the fixed-disk host and drive control logic
// Summary of operation
// - Host data and commands are taken only on I/O write with our decoded address.
// - Host bus is driven only during I/O read with our decoded address.
// - 16-bit transfer indication is given for data port accesses only.
// - Sector data moves as 16-bit words; control and status as bytes.
// - Fixed-disk interrupt rises on data block request or command completion.
// - Interrupt holds until the next command write or a reset clears it.
// - Four binary-coded head select outputs choose one of 16 heads.
// - Write gate is asserted only while a write is intended.
// - Write gate drops on module reset, and on write fault at the next clock with ce high.
// - Read gate asks the selected drive for read data and data recovery.
// - Transfer request starts each command bit out and each status bit in.
// - Drive commands go serially as sixteen data bits then one parity bit.
// - Drive pulses index once per turn; controller counts it for timeouts.
// - Only two drive selects exist: drive 0 or drive 1.
// - Address decode is ignored while address enable is high.
// - Reset clears the interrupt and deselects both drives.
package esdi_pkg;
    // I/O decode: eight byte ports above the base
    localparam logic [9:0] IO_BASE = 10'h300;
    localparam logic [2:0] OFS_DATA = 3'h0;
    localparam logic [2:0] OFS_WORD_LO = 3'h4;
    localparam logic [2:0] OFS_WORD_HI = 3'h5;
    localparam logic [2:0] OFS_DRVHEAD = 3'h6;
    localparam logic [2:0] OFS_CMD = 3'h7;
    // Drive/head port fields
    localparam int DRV_BIT = 4;
    localparam int SEL_BIT = 7;
    // Command codes
    localparam logic [7:0] CMD_GATES_OFF = 8'h00;
    localparam logic [7:0] CMD_READ = 8'h01;
    localparam logic [7:0] CMD_WRITE = 8'h02;
    localparam logic [7:0] CMD_DRIVE = 8'h03;
    localparam logic [7:0] CMD_DRIVE_STAT = 8'h04;
    // Status port bits
    localparam int ST_BUSY = 7;
    localparam int ST_READY = 6;
    localparam int ST_WFAULT = 5;
    localparam int ST_ATTN = 4;
    localparam int ST_SECTOR = 3;
    localparam int ST_ERR = 0;
    // Serial framing and timeout
    localparam logic [4:0] CMD_FRAME_BITS = 5'h11;
    localparam logic [4:0] STAT_BITS = 5'h10;
    localparam logic [3:0] TIMEOUT_INDEX = 4'h3;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [3:0] HEAD_RST = 4'h0;

    typedef enum logic [1:0] {SER_IDLE, SER_REQ, SER_REL} ser_state_t;

    // Odd parity over a command word: total ones including parity is odd
    function automatic logic odd_parity(input logic [15:0] w);
        odd_parity = ~(^w);
    endfunction : odd_parity

    function automatic logic [2:0] port_ofs(input logic [9:0] a);
        port_ofs = a[2:0];
    endfunction : port_ofs
endpackage : esdi_pkg

// ### esdi_serial.sv
// Serial command/status exchange with the drive over the request/acknowledge handshake
`timescale 1ns/100ps
module esdi_serial (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // Controller side
    input wire logic start,
    input wire logic want_reply,
    input wire logic abort,
    input wire logic [15:0] word,
    output logic busy,
    output logic done,
    output logic [15:0] rx_word,
    // Drive side, active low
    output logic tx_req_n,
    output logic cmd_data_n,
    input wire logic tx_ack_n,
    input wire logic csd_n
);
    import esdi_pkg::*;

    ser_state_t state_r, state_nxt;
    logic [16:0] tx_r, tx_nxt;
    logic [15:0] rx_r, rx_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic rx_phase_r, rx_phase_nxt;
    logic reply_r, reply_nxt;
    logic req_r, req_nxt;
    logic done_r, done_nxt;

    always_comb begin
        state_nxt = state_r;
        tx_nxt = tx_r;
        rx_nxt = rx_r;
        cnt_nxt = cnt_r;
        rx_phase_nxt = rx_phase_r;
        reply_nxt = reply_r;
        req_nxt = req_r;
        done_nxt = 1'b0;
        unique case (state_r)
            SER_IDLE: begin
                if (start) begin
                    tx_nxt = {word, odd_parity(word)};
                    cnt_nxt = 5'h00;
                    rx_phase_nxt = 1'b0;
                    reply_nxt = want_reply;
                    req_nxt = 1'b1;
                    state_nxt = SER_REQ;
                end
            end
            SER_REQ: begin
                if (abort) begin
                    req_nxt = 1'b0;
                    state_nxt = SER_IDLE;
                end else if (!tx_ack_n) begin
                    // Status bit is valid with acknowledge
                    if (rx_phase_r) begin
                        rx_nxt = {rx_r[14:0], ~csd_n};
                    end
                    req_nxt = 1'b0;
                    state_nxt = SER_REL;
                end
            end
            SER_REL: begin
                if (abort) begin
                    state_nxt = SER_IDLE;
                end else if (tx_ack_n) begin
                    // Next request only after the drive lets go of acknowledge
                    cnt_nxt = cnt_r + 5'h01;
                    if (!rx_phase_r) begin
                        tx_nxt = {tx_r[15:0], 1'b0};
                    end
                    if (!rx_phase_r && cnt_r + 5'h01 == CMD_FRAME_BITS) begin
                        if (reply_r) begin
                            rx_phase_nxt = 1'b1;
                            cnt_nxt = 5'h00;
                            req_nxt = 1'b1;
                            state_nxt = SER_REQ;
                        end else begin
                            done_nxt = 1'b1;
                            state_nxt = SER_IDLE;
                        end
                    end else if (rx_phase_r && cnt_r + 5'h01 == STAT_BITS) begin
                        done_nxt = 1'b1;
                        state_nxt = SER_IDLE;
                    end else begin
                        req_nxt = 1'b1;
                        state_nxt = SER_REQ;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r <= SER_IDLE;
            tx_r <= 17'h00000;
            rx_r <= WORD_RST;
            cnt_r <= 5'h00;
            rx_phase_r <= 1'b0;
            reply_r <= 1'b0;
            req_r <= 1'b0;
            done_r <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt;
            tx_r <= tx_nxt;
            rx_r <= rx_nxt;
            cnt_r <= cnt_nxt;
            rx_phase_r <= rx_phase_nxt;
            reply_r <= reply_nxt;
            req_r <= req_nxt;
            done_r <= done_nxt;
        end
    end

    assign busy = (state_r != SER_IDLE);
    assign done = done_r;
    assign rx_word = rx_r;
    assign tx_req_n = ~req_r;
    // Line idles high when nothing is being sent
    assign cmd_data_n = ~(tx_r[16] & ~rx_phase_r & busy);
endmodule : esdi_serial

// ### esdi_ctrl.sv
// Fixed-disk host I/O decode, interrupt and drive control cable logic
`timescale 1ns/100ps
module esdi_ctrl #(
    parameter logic [3:0] TIMEOUT_IDX = esdi_pkg::TIMEOUT_INDEX
) (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // Host I/O channel
    input wire logic [9:0] sa,
    input wire logic aen,
    input wire logic bale,
    input wire logic ior_n,
    input wire logic iow_n,
    input wire logic [15:0] sd_in,
    output logic [15:0] sd_out,
    output logic sd_oe_lo,
    output logic sd_oe_hi,
    output logic iocs16_n,
    output logic irq14,
    // Drive control cable
    output logic [3:0] head_sel_n,
    output logic [1:0] drv_sel_n,
    output logic wr_gate_n,
    output logic rd_gate_n,
    output logic tx_req_n,
    output logic cmd_data_n,
    input wire logic tx_ack_n,
    input wire logic csd_n,
    input wire logic attn_n,
    input wire logic sector_n,
    input wire logic index_n,
    input wire logic drv_ready_n,
    input wire logic wr_fault
);
    import esdi_pkg::*;

    // Host cycle tracking
    logic [9:0] addr_r, addr_nxt;
    logic hi_en_r, hi_en_nxt;
    logic iow_d_r, iow_d_nxt;
    logic wr_hit_r, wr_hit_nxt;
    logic [15:0] wdata_r, wdata_nxt;
    logic [15:0] sd_out_r, sd_out_nxt;
    logic oe_lo_r, oe_lo_nxt;
    logic oe_hi_r, oe_hi_nxt;
    logic cs16_r, cs16_nxt;
    // Task state
    logic [15:0] data_r, data_nxt;
    logic [15:0] cword_r, cword_nxt;
    logic [3:0] head_r, head_nxt;
    logic drv_r, drv_nxt;
    logic sel_r, sel_nxt;
    logic wg_r, wg_nxt;
    logic rg_r, rg_nxt;
    logic irq_r, irq_nxt;
    logic err_r, err_nxt;
    logic sect_r, sect_nxt;
    logic index_d_r, index_d_nxt;
    logic [3:0] idx_cnt_r, idx_cnt_nxt;
    logic ser_start_r, ser_start_nxt;
    logic reply_r, reply_nxt;
    logic abort_r, abort_nxt;

    logic ser_busy, ser_done;
    logic [15:0] rx_word;
    logic hit, wr_stb, cmd_wr, ready, idx_edge;
    logic [2:0] ofs;
    logic [7:0] status;

    // Address is taken while the latch enable is high, so the decode holds across the strobe
    assign ofs = port_ofs(addr_r);
    assign hit = (addr_r[9:3] == IO_BASE[9:3]) && !aen;
    // Act at the end of the write strobe, when host data is surely settled
    assign wr_stb = iow_n && !iow_d_r && wr_hit_r;
    assign cmd_wr = wr_stb && (ofs == OFS_CMD);
    assign ready = !drv_ready_n;
    assign idx_edge = !index_n && index_d_r;
    assign status = {ser_busy, ready, wr_fault, ready & !attn_n, sect_r, 2'b00, err_r};

    always_comb begin
        addr_nxt = bale ? sa : addr_r;
        hi_en_nxt = bale ? (port_ofs(sa) == OFS_DATA) : hi_en_r;
        iow_d_nxt = iow_n;
        wr_hit_nxt = !iow_n ? hit : (iow_d_r ? 1'b0 : wr_hit_r);
        wdata_nxt = !iow_n ? sd_in : wdata_r;
        oe_lo_nxt = !ior_n && hit;
        oe_hi_nxt = !ior_n && hit && hi_en_r && (ofs == OFS_DATA);
        cs16_nxt = hit && hi_en_r && (ofs == OFS_DATA);
        sd_out_nxt = 16'h0000;
        unique case (ofs)
            OFS_DATA: sd_out_nxt = data_r;
            OFS_WORD_LO: sd_out_nxt = {8'h00, rx_word[7:0]};
            OFS_WORD_HI: sd_out_nxt = {8'h00, rx_word[15:8]};
            OFS_DRVHEAD: sd_out_nxt = {8'h00, sel_r, 2'b00, drv_r, head_r};
            OFS_CMD: sd_out_nxt = {8'h00, status};
            default: sd_out_nxt = 16'h0000;
        endcase
    end

    always_comb begin
        data_nxt = data_r;
        cword_nxt = cword_r;
        head_nxt = head_r;
        drv_nxt = drv_r;
        sel_nxt = sel_r;
        wg_nxt = wg_r;
        rg_nxt = rg_r;
        irq_nxt = irq_r;
        err_nxt = err_r;
        sect_nxt = sect_r || (ready && !sector_n);
        index_d_nxt = index_n;
        idx_cnt_nxt = ser_busy ? idx_cnt_r : 4'h0;
        ser_start_nxt = 1'b0;
        reply_nxt = reply_r;
        abort_nxt = 1'b0;
        if (wr_stb) begin
            unique case (ofs)
                OFS_DATA: data_nxt = wdata_r;
                OFS_WORD_LO: cword_nxt = {cword_r[15:8], wdata_r[7:0]};
                OFS_WORD_HI: cword_nxt = {wdata_r[7:0], cword_r[7:0]};
                OFS_DRVHEAD: begin
                    head_nxt = wdata_r[3:0];
                    drv_nxt = wdata_r[DRV_BIT];
                    sel_nxt = wdata_r[SEL_BIT];
                end
                default: ;
            endcase
        end
        if (cmd_wr) begin
            irq_nxt = 1'b0;
            err_nxt = 1'b0;
            // A sector mark in the clearing cycle still counts
            sect_nxt = ready && !sector_n;
            unique case (wdata_r[7:0])
                CMD_GATES_OFF: begin
                    wg_nxt = 1'b0;
                    rg_nxt = 1'b0;
                end
                CMD_READ: begin
                    wg_nxt = 1'b0;
                    rg_nxt = ready && sel_r;
                    err_nxt = !(ready && sel_r);
                end
                CMD_WRITE: begin
                    rg_nxt = 1'b0;
                    wg_nxt = ready && sel_r && !wr_fault;
                    err_nxt = !(ready && sel_r && !wr_fault);
                    irq_nxt = 1'b1;
                end
                CMD_DRIVE, CMD_DRIVE_STAT: begin
                    // Serial exchange only to a ready, selected, idle drive
                    ser_start_nxt = ready && sel_r && !ser_busy;
                    reply_nxt = (wdata_r[7:0] == CMD_DRIVE_STAT);
                    err_nxt = !(ready && sel_r && !ser_busy);
                end
                default: err_nxt = 1'b1;
            endcase
        end
        if (ser_busy && idx_edge) begin
            idx_cnt_nxt = idx_cnt_r + 4'h1;
            if (idx_cnt_r + 4'h1 >= TIMEOUT_IDX) begin
                abort_nxt = 1'b1;
                err_nxt = 1'b1;
                irq_nxt = 1'b1;
            end
        end
        // Completion wins over a clear in the same cycle
        if (ser_done) begin
            irq_nxt = 1'b1;
        end
        if (wr_fault) begin
            wg_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            addr_r <= 10'h000;
            hi_en_r <= 1'b0;
            iow_d_r <= 1'b1;
            wr_hit_r <= 1'b0;
            wdata_r <= WORD_RST;
            sd_out_r <= WORD_RST;
            oe_lo_r <= 1'b0;
            oe_hi_r <= 1'b0;
            cs16_r <= 1'b0;
            data_r <= WORD_RST;
            cword_r <= WORD_RST;
            head_r <= HEAD_RST;
            drv_r <= 1'b0;
            sel_r <= 1'b0;
            wg_r <= 1'b0;
            rg_r <= 1'b0;
            irq_r <= 1'b0;
            err_r <= 1'b0;
            sect_r <= 1'b0;
            index_d_r <= 1'b1;
            idx_cnt_r <= 4'h0;
            ser_start_r <= 1'b0;
            reply_r <= 1'b0;
            abort_r <= 1'b0;
        end else if (ce) begin
            addr_r <= addr_nxt;
            hi_en_r <= hi_en_nxt;
            iow_d_r <= iow_d_nxt;
            wr_hit_r <= wr_hit_nxt;
            wdata_r <= wdata_nxt;
            sd_out_r <= sd_out_nxt;
            oe_lo_r <= oe_lo_nxt;
            oe_hi_r <= oe_hi_nxt;
            cs16_r <= cs16_nxt;
            data_r <= data_nxt;
            cword_r <= cword_nxt;
            head_r <= head_nxt;
            drv_r <= drv_nxt;
            sel_r <= sel_nxt;
            wg_r <= wg_nxt;
            rg_r <= rg_nxt;
            irq_r <= irq_nxt;
            err_r <= err_nxt;
            sect_r <= sect_nxt;
            index_d_r <= index_d_nxt;
            idx_cnt_r <= idx_cnt_nxt;
            ser_start_r <= ser_start_nxt;
            reply_r <= reply_nxt;
            abort_r <= abort_nxt;
        end
    end

    esdi_serial u_serial (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .start(ser_start_r),
        .want_reply(reply_r),
        .abort(abort_r),
        .word(cword_r),
        .busy(ser_busy),
        .done(ser_done),
        .rx_word(rx_word),
        .tx_req_n(tx_req_n),
        .cmd_data_n(cmd_data_n),
        .tx_ack_n(tx_ack_n),
        .csd_n(csd_n)
    );

    assign sd_out = sd_out_r;
    assign sd_oe_lo = oe_lo_r;
    assign sd_oe_hi = oe_hi_r;
    assign iocs16_n = ~cs16_r;
    assign irq14 = irq_r;
    assign head_sel_n = ~head_r;
    assign drv_sel_n = ~{sel_r & drv_r, sel_r & ~drv_r};
    assign wr_gate_n = ~wg_r;
    assign rd_gate_n = ~rg_r;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_wgate_fault: assert property (ce && wr_fault |=> wr_gate_n)
        else $error("write gate stayed on after write fault");
    chk_wgate_reset: assert property (@(posedge core_clk) disable iff (1'b0) rst |=> wr_gate_n &&
        drv_sel_n == 2'b11 && !irq14)
        else $error("reset did not clear gate, selects and interrupt");
    chk_irq_done: assert property (ce && ser_done |=> irq14)
        else $error("interrupt not raised on command completion");
    chk_irq_clear: assert property (ce && cmd_wr && !ser_done && !(ser_busy && idx_edge) &&
        wdata_r[7:0] != CMD_WRITE |=> !irq14)
        else $error("interrupt not cleared by command write");
    chk_irq_hold: assert property (ce && irq14 && !cmd_wr |=> irq14)
        else $error("interrupt dropped without command write");
    chk_oe_read: assert property (sd_oe_lo |-> !$past(ior_n) && $past(hit))
        else $error("bus driven outside a decoded read");
    chk_cs16_data: assert property (!iocs16_n |-> $past(ofs) == OFS_DATA)
        else $error("16-bit indication on a byte port");
    chk_drv_sel: assert property (drv_sel_n != 2'b00)
        else $error("both drives selected");
    chk_req_ack: assert property (!tx_req_n && tx_ack_n && !abort_r && ce |=> !tx_req_n)
        else $error("request dropped before acknowledge");
    chk_wgate_intent: assert property ($fell(wr_gate_n) |-> $past(cmd_wr) && $past(wdata_r[7:0]) == CMD_WRITE)
        else $error("write gate raised without intent");

    cov_cmd_send: cover property (ser_start_r ##[1:400] ser_done);
    cov_timeout: cover property (abort_r);
    cov_write_gate: cover property ($fell(wr_gate_n));
    cov_data_read: cover property (sd_oe_hi && !iocs16_n);
endmodule : esdi_ctrl

// ### esdi_drive_model.sv
// Behavioural drive on the control cable: handshake, command capture, status return
`timescale 1ns/100ps
module esdi_drive_model (
    // Clock
    input wire logic core_clk,
    // Control cable
    input wire logic sel_n,
    input wire logic tx_req_n,
    input wire logic cmd_data_n,
    output logic tx_ack_n,
    output logic csd_n,
    // Bench controls
    input wire logic clr,
    input wire logic [7:0] ack_dly,
    input wire logic [15:0] reply_word,
    output logic [16:0] got_frame
);
    logic [5:0] bit_cnt;

    initial begin
        tx_ack_n = 1'b1;
        csd_n = 1'b1;
        got_frame = '0;
        bit_cnt = '0;
        forever begin
            @(posedge core_clk);
            if (clr) begin
                bit_cnt <= '0;
                got_frame <= '0;
            end else if (tx_req_n === 1'b0 && sel_n === 1'b0) begin
                // A slow drive may sit on a request for many cycles; a withdrawn request gets no answer
                for (int i = 0; i < ack_dly && tx_req_n === 1'b0; i++) @(posedge core_clk);
                if (tx_req_n === 1'b0) begin
                    if (bit_cnt < 6'd17) begin
                        got_frame <= {got_frame[15:0], ~cmd_data_n};
                    end else begin
                        csd_n <= ~reply_word[6'd32 - bit_cnt];
                    end
                    bit_cnt <= bit_cnt + 6'd1;
                    tx_ack_n <= 1'b0;
                    @(posedge core_clk);
                    while (tx_req_n !== 1'b1) @(posedge core_clk);
                    tx_ack_n <= 1'b1;
                    // Released line must not look like a held bit
                    csd_n <= ~csd_n;
                end
            end
        end
    end
endmodule : esdi_drive_model

// ### tb.sv
// Self-checking bench for the fixed-disk host and drive control block
`timescale 1ns/100ps
module tb;
    import esdi_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [9:0] sa = 10'h000;
    logic aen = 1'b0;
    logic bale = 1'b0;
    logic ior_n = 1'b1;
    logic iow_n = 1'b1;
    logic [15:0] sd_in = 16'h0000;
    logic attn_n = 1'b1;
    logic sector_n = 1'b1;
    logic index_n = 1'b1;
    logic drv_ready_n = 1'b0;
    logic wr_fault = 1'b0;
    logic ce = 1'b1;
    logic model_clr = 1'b0;
    logic [7:0] ack_dly = 8'h00;
    logic [15:0] reply_word = 16'h0000;
    logic [16:0] got_frame;
    logic [15:0] sd_out;
    logic sd_oe_lo, sd_oe_hi, iocs16_n, irq14, wr_gate_n, rd_gate_n, tx_req_n, cmd_data_n, tx_ack_n, csd_n;
    logic [3:0] head_sel_n;
    logic [1:0] drv_sel_n;
    logic [15:0] rd;
    logic [2:0] fl;
    int fail_count = 0;
    int checks = 0;
    int cycles = 0;

    always #5 core_clk = ~core_clk;

    // Short timeout count keeps the abort scenario brief
    esdi_ctrl #(.TIMEOUT_IDX(4'h1)) dut (.core_clk(core_clk), .rst(rst), .ce(ce), .sa(sa), .aen(aen),
        .bale(bale), .ior_n(ior_n), .iow_n(iow_n), .sd_in(sd_in), .sd_out(sd_out), .sd_oe_lo(sd_oe_lo),
        .sd_oe_hi(sd_oe_hi), .iocs16_n(iocs16_n), .irq14(irq14), .head_sel_n(head_sel_n),
        .drv_sel_n(drv_sel_n), .wr_gate_n(wr_gate_n), .rd_gate_n(rd_gate_n), .tx_req_n(tx_req_n),
        .cmd_data_n(cmd_data_n), .tx_ack_n(tx_ack_n), .csd_n(csd_n), .attn_n(attn_n), .sector_n(sector_n),
        .index_n(index_n), .drv_ready_n(drv_ready_n), .wr_fault(wr_fault));

    esdi_drive_model drive (.core_clk(core_clk), .sel_n(drv_sel_n[0]), .tx_req_n(tx_req_n),
        .cmd_data_n(cmd_data_n), .tx_ack_n(tx_ack_n), .csd_n(csd_n), .clr(model_clr), .ack_dly(ack_dly),
        .reply_word(reply_word), .got_frame(got_frame));

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            finish_test();
        end
    end

    task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic io_wr(input logic [9:0] a, input logic [15:0] d);
        @(posedge core_clk);
        bale <= 1'b1;
        sa <= a;
        @(posedge core_clk);
        bale <= 1'b0;
        iow_n <= 1'b0;
        sd_in <= d;
        repeat (2) @(posedge core_clk);
        iow_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
    endtask : io_wr

    task automatic io_rd(input logic [9:0] a);
        @(posedge core_clk);
        bale <= 1'b1;
        sa <= a;
        @(posedge core_clk);
        bale <= 1'b0;
        ior_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        rd = sd_out;
        fl = {sd_oe_hi, sd_oe_lo, iocs16_n};
        @(posedge core_clk);
        ior_n <= 1'b1;
        repeat (2) @(posedge core_clk);
    endtask : io_rd

    task automatic cmd(input logic [7:0] c);
        io_wr(IO_BASE + 10'h7, {8'h00, c});
    endtask : cmd

    task automatic t_reset();
        @(negedge core_clk);
        check("idle", {irq14, drv_sel_n, head_sel_n, wr_gate_n, rd_gate_n}, 17'h000ff);
        check("idle_io", {tx_req_n, cmd_data_n, sd_oe_hi, sd_oe_lo, iocs16_n}, 17'h00019);
        check("idle_data", sd_out, 17'h00000);
    endtask : t_reset

    task automatic t_select();
        logic [3:0] h;
        for (int i = 0; i < 4; i++) begin
            h = 4'(i * 5);
            io_wr(IO_BASE + 10'h6, {8'h00, 3'b100, h[0], h});
            check("sel", {drv_sel_n, head_sel_n}, {h[0] ? 2'b01 : 2'b10, ~h});
        end
        io_wr(IO_BASE + 10'h6, 16'h0003);
        check("desel", drv_sel_n, 2'b11);
        io_wr(IO_BASE + 10'h6, 16'h0085);
        aen <= 1'b1;
        io_wr(IO_BASE + 10'h6, 16'h009f);
        aen <= 1'b0;
        io_wr(10'h316, 16'h009f);
        check("ignored", {drv_sel_n, head_sel_n}, {2'b10, 4'ha});
    endtask : t_select

    task automatic t_host();
        io_wr(IO_BASE, 16'hbeef);
        io_rd(IO_BASE);
        check("word", {fl, rd}, {3'b110, 16'hbeef});
        io_rd(IO_BASE + 10'h7);
        check("byte", {fl, rd[15:8]}, {3'b011, 8'h00});
        aen <= 1'b1;
        io_rd(IO_BASE);
        aen <= 1'b0;
        check("aen_rd", fl, 3'b001);
        io_rd(IO_BASE + 10'h8);
        check("miss_rd", fl, 3'b001);
    endtask : t_host

    task automatic t_gates();
        // A frozen block must let a whole host write pass unseen
        ce <= 1'b0;
        cmd(CMD_READ);
        ce <= 1'b1;
        check("frozen", rd_gate_n, 1'b1);
        cmd(CMD_READ);
        check("rgate", {rd_gate_n, wr_gate_n}, 2'b01);
        cmd(CMD_WRITE);
        check("wgate", {wr_gate_n, irq14}, 2'b01);
        cmd(CMD_GATES_OFF);
        check("off", {rd_gate_n, wr_gate_n, irq14}, 3'b110);
        cmd(CMD_WRITE);
        wr_fault <= 1'b1;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        check("fault", wr_gate_n, 1'b1);
        wr_fault <= 1'b0;
        cmd(CMD_WRITE);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        fl = 3'b001;
        t_reset();
        io_wr(IO_BASE + 10'h6, 16'h0080);
    endtask : t_gates

    task automatic t_status();
        cmd(CMD_GATES_OFF);
        sector_n <= 1'b0;
        attn_n <= 1'b0;
        @(posedge core_clk);
        sector_n <= 1'b1;
        io_rd(IO_BASE + 10'h7);
        check("status", rd[7:0], 8'h58);
        attn_n <= 1'b1;
        cmd(8'h55);
        io_rd(IO_BASE + 10'h7);
        check("bad_cmd", rd[7:0], 8'h41);
    endtask : t_status

    task automatic wait_irq();
        int n;
        for (n = 0; n < 3000 && irq14 !== 1'b1; n++) @(posedge core_clk);
        check("irq", irq14, 1'b1);
    endtask : wait_irq

    task automatic t_serial(input logic [7:0] c, input logic [15:0] w, input logic [15:0] rep, input logic [7:0] dly);
        logic [7:0] lo;
        ack_dly <= dly;
        reply_word <= rep;
        model_clr <= 1'b1;
        @(posedge core_clk);
        model_clr <= 1'b0;
        io_wr(IO_BASE + 10'h4, {8'h00, w[7:0]});
        io_wr(IO_BASE + 10'h5, {8'h00, w[15:8]});
        cmd(c);
        wait_irq();
        check("frame", got_frame, {w, ~(^w)});
        if (c == CMD_DRIVE_STAT) begin
            io_rd(IO_BASE + 10'h4);
            lo = rd[7:0];
            io_rd(IO_BASE + 10'h5);
            check("reply", {1'b0, rd[7:0], lo}, {1'b0, rep});
        end
    endtask : t_serial

    task automatic t_timeout();
        ack_dly <= 8'hff;
        cmd(CMD_DRIVE);
        index_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        index_n <= 1'b1;
        wait_irq();
        io_rd(IO_BASE + 10'h7);
        check("timeout", rd[7:0], 8'h41);
    endtask : t_timeout

    initial begin
        fl = 3'b001;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_select();
        t_host();
        t_gates();
        t_status();
        t_serial(CMD_DRIVE, 16'ha5c3, 16'h0000, 8'h00);
        t_serial(CMD_DRIVE_STAT, 16'h8001, 16'h3c96, 8'h03);
        t_serial(CMD_DRIVE_STAT, 16'hffff, 16'hc001, 8'h00);
        t_timeout();
        finish_test();
    end
endmodule : tb
